/* fvs_pkg.sv */
package fvs_pkg;
  // volatile status one bit positions, plus the config one BP source bit (CFG_BPSRC)
  localparam int unsigned BIT_LOCK  = 7;
  localparam int unsigned BIT_PERR  = 6;
  localparam int unsigned BIT_EERR  = 5;
  localparam int unsigned BP_HI     = 4;
  localparam int unsigned BP_LO     = 2;
  localparam int unsigned BIT_WEL   = 1;
  localparam int unsigned BIT_BUSY  = 0;
  localparam int unsigned CFG_BPSRC = 3;
  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD_A = 8'h30;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD_B = 8'h82;
  localparam logic [7:0] OP_READ_ANY_REGISTER_CMD   = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY_REGISTER_CMD   = 8'h71;
  localparam logic [7:0] OP_WRR    = 8'h01;
  localparam logic [7:0] OP_STATUS_ONE_READ_CMD  = 8'h05;
  localparam logic [7:0] OP_STATUS_TWO_READ_CMD  = 8'h07;
  localparam logic [7:0] OP_ERASE_SUSPEND_CMD   = 8'h75;
  localparam logic [7:0] OP_PROGRAM_SUSPEND_CMD   = 8'h85;
  localparam logic [7:0] OP_RESET  = 8'hf0;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SE     = 8'hd8;
  localparam logic [7:0] OP_BE     = 8'h60;
  localparam logic [7:0] OP_OTPP   = 8'h42;
  localparam logic [2:0] BP_CLEAR  = 3'h0;
  typedef enum logic [1:0] {FVS_NONE, FVS_PROG, FVS_ERASE, FVS_WRITE} fvs_op_t;
  typedef enum {FVS_IDLE, FVS_RUN, FVS_STUCK} fvs_state_t;
endpackage

/* fvs_cmd_if.sv */
`timescale 1ns/1ps
interface fvs_cmd_if;
  logic       valid;
  logic [7:0] opcode;
  logic       busy;
  logic       write_enable_latch;
  logic       accept;
  modport dec (input valid, opcode, busy, write_enable_latch, output accept);
  modport top (output valid, opcode, busy, write_enable_latch, input accept);
endinterface

/* fvs_cmd_gate.sv */
`timescale 1ns/1ps
module fvs_cmd_gate
  import fvs_pkg::*;
(
  fvs_cmd_if.dec cmd
);
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == OP_STATUS_ONE_READ_CMD) || (op == OP_STATUS_TWO_READ_CMD) || (op == OP_READ_ANY_REGISTER_CMD) ||
              (op == OP_ERASE_SUSPEND_CMD) || (op == OP_PROGRAM_SUSPEND_CMD) || (op == OP_CLEAR_STATUS_CMD_A) ||
              (op == OP_CLEAR_STATUS_CMD_B) || (op == OP_RESET);
  endfunction
  function automatic logic needs_wel(input logic [7:0] op);
    needs_wel = (op == OP_WRR) || (op == OP_WRITE_ANY_REGISTER_CMD) || (op == OP_PP) ||
                (op == OP_SE) || (op == OP_BE) || (op == OP_OTPP);
  endfunction
  always_comb begin
    cmd.accept = cmd.valid;
    if (cmd.busy && !busy_ok(cmd.opcode)) begin
      cmd.accept = 1'b0;
    end
    if (needs_wel(cmd.opcode) && !cmd.write_enable_latch) begin
      cmd.accept = 1'b0;
    end
  end
endmodule

/* fvs_status_one.sv */
`timescale 1ns/1ps
module fvs_status_one
  import fvs_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic       SOFT_RESET,
  input  wire logic       CMD_VALID,
  input  wire logic [7:0] CMD_OPCODE,
  input  wire logic       CMD_TARGET_SR1,
  input  wire logic       CMD_TARGET_CR1,
  input  wire logic [7:0] CMD_DATA,
  input  wire logic       TARGET_PROTECTED,
  input  wire logic       TARGET_OTP_LOCKED,
  input  wire logic       WP_N,
  input  wire logic [7:0] NONVOLATILE_STATUS_ONE,
  input  wire logic [7:0] NONVOLATILE_CONFIG_ONE,
  input  wire logic       OP_DONE,
  input  wire logic       OP_FAIL,
  output logic [7:0]      VOLATILE_STATUS_ONE,
  output logic            CMD_ACCEPTED,
  output logic            START_PROG,
  output logic            START_ERASE,
  output logic            START_CHIP_ERASE,
  output logic            START_WRITE,
  output logic            NV_BP_WRITE,
  output logic [2:0]      NV_BP_DATA,
  output logic            SUSPEND_PROG,
  output logic            SUSPEND_ERASE
);
  fvs_cmd_if  cmd ();
  fvs_state_t state;
  fvs_op_t    op_kind;
  logic       chip_erase;
  logic       perr;
  logic       eerr;
  logic [2:0] bp_vol;
  logic       write_enable_latch;
  logic       defaults_pending;
  logic       bp_src_vol;
  logic [2:0] bp_active;
  logic       busy;
  logic       acc;
  logic       is_prog;
  logic       is_erase;
  logic       is_clear_status_cmd;
  logic       wr_lock;
  logic       wr_reg;
  logic       bad_prog;
  logic       bad_erase;
  logic       refused_be;

  assign cmd.valid  = CMD_VALID;
  assign cmd.opcode = CMD_OPCODE;
  assign cmd.busy   = busy;
  assign cmd.write_enable_latch    = write_enable_latch;

  fvs_cmd_gate u_gate (
    .cmd (cmd)
  );

  assign busy       = (state != FVS_IDLE);
  assign acc        = cmd.accept;
  assign bp_src_vol = NONVOLATILE_CONFIG_ONE[CFG_BPSRC];
  assign bp_active  = bp_src_vol ? bp_vol : NONVOLATILE_STATUS_ONE[BP_HI:BP_LO];
  assign is_prog    = (CMD_OPCODE == OP_PP) || (CMD_OPCODE == OP_OTPP);
  assign is_erase   = (CMD_OPCODE == OP_SE) || (CMD_OPCODE == OP_BE);
  assign is_clear_status_cmd    = (CMD_OPCODE == OP_CLEAR_STATUS_CMD_A) || (CMD_OPCODE == OP_CLEAR_STATUS_CMD_B);
  assign wr_lock    = NONVOLATILE_STATUS_ONE[BIT_LOCK] && !WP_N;
  assign wr_reg     = acc && ((CMD_OPCODE == OP_WRR) ||
                      ((CMD_OPCODE == OP_WRITE_ANY_REGISTER_CMD) && (CMD_TARGET_SR1 || CMD_TARGET_CR1)))
                      && !wr_lock;
  // protection lookup is outside; the caller flags a protected target
  assign bad_prog   = acc && is_prog &&
                      (TARGET_PROTECTED || (CMD_OPCODE == OP_OTPP && TARGET_OTP_LOCKED));
  assign bad_erase  = acc && (CMD_OPCODE == OP_SE) && TARGET_PROTECTED;
  assign refused_be = acc && (CMD_OPCODE == OP_BE) && (bp_active != BP_CLEAR);

  // operation sequencing
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state      <= FVS_IDLE;
      op_kind    <= FVS_NONE;
      chip_erase <= 1'b0;
    end else if (SOFT_RESET || defaults_pending) begin
      state      <= FVS_IDLE;
      op_kind    <= FVS_NONE;
      chip_erase <= 1'b0;
      if (defaults_pending && NONVOLATILE_STATUS_ONE[BIT_BUSY]) begin
        state <= FVS_RUN;
      end
    end else begin
      case (state)
        FVS_IDLE: begin
          if (bad_prog || bad_erase) begin
            state <= FVS_STUCK;
          end else if (acc && is_prog) begin
            state   <= FVS_RUN;
            op_kind <= FVS_PROG;
          end else if (acc && is_erase && !refused_be) begin
            state      <= FVS_RUN;
            op_kind    <= FVS_ERASE;
            chip_erase <= (CMD_OPCODE == OP_BE);
          end else if (wr_reg) begin
            state   <= FVS_RUN;
            op_kind <= FVS_WRITE;
          end
        end
        FVS_RUN: begin
          if (OP_DONE) begin
            op_kind <= FVS_NONE;
            if (OP_FAIL && !(op_kind == FVS_WRITE)) begin
              state <= FVS_STUCK;
            end else begin
              state <= FVS_IDLE;
            end
          end
        end
        FVS_STUCK: begin
          if (acc && is_clear_status_cmd) begin
            state <= FVS_IDLE;
          end
        end
        default: state <= FVS_IDLE;
      endcase
    end
  end

  // error flags: hardware sets win over clear-status in the same cycle
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      perr <= 1'b0;
      eerr <= 1'b0;
    end else if (SOFT_RESET || defaults_pending) begin
      perr <= NONVOLATILE_STATUS_ONE[BIT_PERR];
      eerr <= NONVOLATILE_STATUS_ONE[BIT_EERR];
    end else begin
      if (acc && is_clear_status_cmd) begin
        perr <= 1'b0;
        eerr <= 1'b0;
      end
      if (bad_prog || (state == FVS_RUN && OP_DONE && OP_FAIL && op_kind == FVS_PROG)) begin
        perr <= 1'b1;
      end
      // chip erase skips protected sectors silently
      if (bad_erase || (state == FVS_RUN && OP_DONE && OP_FAIL &&
                        op_kind == FVS_ERASE && !chip_erase)) begin
        eerr <= 1'b1;
      end
      // register writes never reach perr/eerr
    end
  end

  // volatile protect bits
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      bp_vol <= BP_CLEAR;
    end else if (SOFT_RESET || defaults_pending) begin
      bp_vol <= NONVOLATILE_STATUS_ONE[BP_HI:BP_LO];
    end else if (state == FVS_IDLE && wr_reg && CMD_TARGET_SR1 && bp_src_vol) begin
      bp_vol <= CMD_DATA[BP_HI:BP_LO];
    end else if (!bp_src_vol) begin
      bp_vol <= NONVOLATILE_STATUS_ONE[BP_HI:BP_LO];
    end
  end

  // write enable latch
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      write_enable_latch              <= 1'b0;
      defaults_pending <= 1'b1;
    end else if (SOFT_RESET || defaults_pending) begin
      write_enable_latch              <= 1'b0;
      defaults_pending <= 1'b0;
    end else if (acc && CMD_OPCODE == OP_WRITE_ENABLE_CMD) begin
      write_enable_latch <= 1'b1;
    end else if (acc && CMD_OPCODE == OP_WRITE_DISABLE_CMD) begin
      write_enable_latch <= 1'b0;
    end else if (state == FVS_RUN && OP_DONE && !OP_FAIL) begin
      write_enable_latch <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      VOLATILE_STATUS_ONE <= 8'h00;
      CMD_ACCEPTED        <= 1'b0;
      START_PROG          <= 1'b0;
      START_ERASE         <= 1'b0;
      START_CHIP_ERASE    <= 1'b0;
      START_WRITE         <= 1'b0;
      NV_BP_WRITE         <= 1'b0;
      NV_BP_DATA          <= BP_CLEAR;
      SUSPEND_PROG        <= 1'b0;
      SUSPEND_ERASE       <= 1'b0;
    end else begin
      VOLATILE_STATUS_ONE[BIT_LOCK]    <= NONVOLATILE_STATUS_ONE[BIT_LOCK];
      VOLATILE_STATUS_ONE[BIT_PERR]    <= perr;
      VOLATILE_STATUS_ONE[BIT_EERR]    <= eerr;
      VOLATILE_STATUS_ONE[BP_HI:BP_LO] <= bp_vol;
      VOLATILE_STATUS_ONE[BIT_WEL]     <= write_enable_latch;
      VOLATILE_STATUS_ONE[BIT_BUSY]    <= busy;
      CMD_ACCEPTED     <= acc && !defaults_pending;
      START_PROG       <= state == FVS_IDLE && acc && is_prog && !bad_prog;
      START_ERASE      <= state == FVS_IDLE && acc && CMD_OPCODE == OP_SE && !bad_erase;
      START_CHIP_ERASE <= state == FVS_IDLE && acc && CMD_OPCODE == OP_BE && !refused_be;
      START_WRITE      <= state == FVS_IDLE && wr_reg;
      NV_BP_WRITE      <= state == FVS_IDLE && wr_reg && CMD_TARGET_SR1 && !bp_src_vol;
      NV_BP_DATA       <= CMD_DATA[BP_HI:BP_LO];
      SUSPEND_PROG     <= acc && CMD_OPCODE == OP_PROGRAM_SUSPEND_CMD &&
                          state == FVS_RUN && op_kind == FVS_PROG;
      SUSPEND_ERASE    <= acc && CMD_OPCODE == OP_ERASE_SUSPEND_CMD &&
                          state == FVS_RUN && op_kind == FVS_ERASE;
    end
  end
endmodule

/* fvs_status_one_sva.sv */
`timescale 1ns/1ps
module fvs_status_one_sva
  import fvs_pkg::*;
(
  input logic       CLOCK,
  input logic       NRST,
  input logic       CMD_VALID,
  input logic [7:0] CMD_OPCODE,
  input logic       WP_N,
  input logic [7:0] NONVOLATILE_STATUS_ONE,
  input logic       OP_DONE,
  input logic       OP_FAIL,
  input logic [7:0] VOLATILE_STATUS_ONE,
  input logic       CMD_ACCEPTED,
  input logic       START_PROG,
  input logic       START_WRITE
);
  logic [1:0] up;
  wire  [7:0] s  = VOLATILE_STATUS_ONE;
  wire  [7:0] o  = CMD_OPCODE;
  wire        v  = CMD_VALID;
  wire        lk = NONVOLATILE_STATUS_ONE[7];
  // status lags two cycles, so the default-load cycles are skipped
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!NRST || up != 2'h3);
  property p_mirror; $stable(lk) && $past(lk) == $past(lk, 2) |-> s[7] == lk; endproperty
  property p_write_enable_cmd; v && o == OP_WRITE_ENABLE_CMD && !s[0] && !CMD_ACCEPTED |=> CMD_ACCEPTED ##1 s[1];
  endproperty
  property p_gate; v && o == OP_PP && !s[1] && !CMD_ACCEPTED |=> !START_PROG; endproperty
  property p_busy; v && o == OP_WRITE_ENABLE_CMD && s[0] && !$past(OP_DONE) |=> !CMD_ACCEPTED; endproperty
  property p_done; OP_DONE && !OP_FAIL && s[0] && s[6:5] == 2'h0 |-> ##2 s[1:0] == 2'h0;
  endproperty
  property p_stuck; s[6] || s[5] |-> s[0]; endproperty
  property p_clear_status_cmd; v && (o == OP_CLEAR_STATUS_CMD_A || o == OP_CLEAR_STATUS_CMD_B) && !OP_DONE |-> ##2 s[6:5] == 2'h0;
  endproperty
  property p_lock; v && o == OP_WRR && lk && $past(lk) && !WP_N |=> !START_WRITE; endproperty
  a_mirror: assert property (p_mirror) else $error("lock copy wrong");
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("latch not set");
  a_gate: assert property (p_gate) else $error("program without latch");
  a_busy: assert property (p_busy) else $error("command taken while busy");
  a_done: assert property (p_done) else $error("busy or latch kept");
  a_stuck: assert property (p_stuck) else $error("error without busy");
  a_clear_status_cmd: assert property (p_clear_status_cmd) else $error("errors not cleared");
  a_lock: assert property (p_lock) else $error("locked write started");
  c_prog: cover property (START_PROG);
  c_err: cover property (s[6]);
  c_wr: cover property (START_WRITE);
endmodule
bind fvs_status_one fvs_status_one_sva i_fvs_status_one_sva (.*);

/* fvs_host.sv */
`timescale 1ns/1ps
module fvs_host
  import fvs_pkg::*;
(
  input  logic       clk,
  output logic       valid = 1'b0,
  output logic [7:0] op = 8'h00,
  output logic [7:0] data = 8'h00,
  output logic       done = 1'b0,
  output logic       fail = 1'b0
);
  // op, data and fail are inverted once released, valid and done drop to 0, so stale values never read as fresh
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    valid = 1'b1;
    op = c;
    data = d;
    @(negedge clk);
    valid = 1'b0;
    op = ~c;
    data = ~d;
  endtask
  task automatic finish(input logic f);
    @(negedge clk);
    done = 1'b1;
    fail = f;
    @(negedge clk);
    done = 1'b0;
    fail = ~f;
  endtask
endmodule

/* fvs_status_one_tb.sv */
`timescale 1ns/1ps
module fvs_status_one_tb;
  import fvs_pkg::*;
  logic CLOCK = 1'b0, NRST = 1'b0, SOFT_RESET = 1'b0, CMD_VALID, CMD_TARGET_SR1 = 1'b1;
  logic CMD_TARGET_CR1 = 1'b0, TARGET_PROTECTED = 1'b0, TARGET_OTP_LOCKED = 1'b0, WP_N = 1'b1;
  logic OP_DONE, OP_FAIL, CMD_ACCEPTED, START_PROG, START_ERASE, START_CHIP_ERASE, START_WRITE;
  logic NV_BP_WRITE, SUSPEND_PROG, SUSPEND_ERASE;
  logic [7:0] CMD_OPCODE, CMD_DATA, VOLATILE_STATUS_ONE, NONVOLATILE_STATUS_ONE = 8'h00;
  logic [7:0] NONVOLATILE_CONFIG_ONE = 8'h00;
  logic [2:0] NV_BP_DATA, bp_seen;
  int fail_count = 0, compares = 0, cyc = 0, n_acc = 0, n_st = 0, n_nv = 0;
  int n_sp = 0, n_ser = 0, n_er = 0;
  always #2.5 CLOCK = ~CLOCK;
  fvs_status_one i_fvs_status_one (.*);
  fvs_host i_fvs_host (.clk(CLOCK), .valid(CMD_VALID), .op(CMD_OPCODE), .data(CMD_DATA),
    .done(OP_DONE), .fail(OP_FAIL));
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    n_acc <= n_acc + int'(CMD_ACCEPTED);
    n_sp <= n_sp + int'(SUSPEND_PROG);
    n_ser <= n_ser + int'(SUSPEND_ERASE);
    n_er <= n_er + int'(START_ERASE);
    n_st <= n_st + int'(START_PROG) + int'(START_ERASE) + int'(START_CHIP_ERASE)
      + int'(START_WRITE);
    if (NV_BP_WRITE) begin
      n_nv <= n_nv + 1;
      bp_seen <= NV_BP_DATA;
    end
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] d = 8'h00);
    i_fvs_host.send(c, d);
    repeat (2) @(negedge CLOCK);
  endtask
  task automatic done(input logic f);
    i_fvs_host.finish(f);
    repeat (2) @(negedge CLOCK);
  endtask
  task automatic t_reset;
    chk("status", VOLATILE_STATUS_ONE, 8'h00);
    NONVOLATILE_STATUS_ONE = 8'h80;
    repeat (3) @(negedge CLOCK);
    chk("lock copy", VOLATILE_STATUS_ONE, 8'h80);
    NONVOLATILE_STATUS_ONE = 8'h00;
    cmd(OP_WRITE_ENABLE_CMD);
    chk("latch", VOLATILE_STATUS_ONE, 8'h02);
    SOFT_RESET = 1'b1;
    @(negedge CLOCK);
    SOFT_RESET = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk("latch", VOLATILE_STATUS_ONE, 8'h00);
  endtask
  task automatic t_ops;
    int a;
    cmd(OP_PP);
    chk("starts", 8'(n_st), 8'h00);
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_PP);
    chk("status", VOLATILE_STATUS_ONE, 8'h03);
    a = n_acc;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_STATUS_ONE_READ_CMD);
    chk("accepts", 8'(n_acc - a), 8'h01);
    repeat (5) @(negedge CLOCK);
    done(1'b0);
    chk("status", VOLATILE_STATUS_ONE, 8'h00);
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_WRITE_DISABLE_CMD);
    chk("status", VOLATILE_STATUS_ONE, 8'h00);
  endtask
  task automatic t_err;
    int s;
    for (int i = 0; i < 4; i++) begin
      TARGET_PROTECTED = i[1];
      s = n_st;
      cmd(OP_WRITE_ENABLE_CMD);
      cmd(i[0] ? OP_SE : OP_PP);
      if (!i[1]) done(1'b1);
      chk("error", VOLATILE_STATUS_ONE & 8'hfd, i[0] ? 8'h21 : 8'h41);
      chk("starts", 8'(n_st - s), 8'(!i[1]));
      cmd(i[0] ? OP_CLEAR_STATUS_CMD_B : OP_CLEAR_STATUS_CMD_A);
      chk("cleared", VOLATILE_STATUS_ONE & 8'hfd, 8'h00);
      cmd(OP_WRITE_DISABLE_CMD);
    end
    TARGET_PROTECTED = 1'b0;
  endtask
  task automatic t_bp;
    int s;
    NONVOLATILE_CONFIG_ONE = 8'h08;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_WRR, 8'h7f);
    done(1'b0);
    chk("status", VOLATILE_STATUS_ONE, 8'h1c);
    chk("nv writes", 8'(n_nv), 8'h00);
    s = n_st;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_BE);
    chk("starts", 8'(n_st - s), 8'h00);
    cmd(OP_WRITE_DISABLE_CMD);
    NONVOLATILE_CONFIG_ONE = 8'h00;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_WRR, 8'h14);
    done(1'b0);
    chk("nv data", {5'h0, bp_seen}, 8'h05);
    NONVOLATILE_STATUS_ONE = {3'h0, bp_seen, 2'h0};
    repeat (3) @(negedge CLOCK);
    chk("status", VOLATILE_STATUS_ONE, 8'h14);
    NONVOLATILE_STATUS_ONE = 8'h00;
    s = n_st;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_BE);
    chk("starts", 8'(n_st - s), 8'h01);
    done(1'b0);
  endtask
  task automatic t_more;
    int p, e, r;
    p = n_sp;
    e = n_ser;
    r = n_er;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_PP);
    cmd(OP_ERASE_SUSPEND_CMD);
    cmd(OP_PROGRAM_SUSPEND_CMD);
    done(1'b0);
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_SE);
    cmd(OP_PROGRAM_SUSPEND_CMD);
    cmd(OP_ERASE_SUSPEND_CMD);
    done(1'b0);
    chk("prog suspends", 8'(n_sp - p), 8'h01);
    chk("erase suspends", 8'(n_ser - e), 8'h01);
    chk("erase starts", 8'(n_er - r), 8'h01);
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_BE);
    done(1'b1);
    chk("chip erase error", VOLATILE_STATUS_ONE & 8'h20, 8'h00);
    cmd(OP_CLEAR_STATUS_CMD_A);
    cmd(OP_WRITE_DISABLE_CMD);
    TARGET_OTP_LOCKED = 1'b1;
    cmd(OP_WRITE_ENABLE_CMD);
    cmd(OP_OTPP);
    chk("otp error", VOLATILE_STATUS_ONE & 8'hfd, 8'h41);
    TARGET_OTP_LOCKED = 1'b0;
    cmd(OP_CLEAR_STATUS_CMD_B);
    cmd(OP_WRITE_DISABLE_CMD);
  endtask
  task automatic t_lock;
    int s;
    NONVOLATILE_STATUS_ONE = 8'h80;
    WP_N = 1'b0;
    cmd(OP_WRITE_ENABLE_CMD);
    s = n_st;
    cmd(OP_WRR, 8'h1c);
    chk("starts", 8'(n_st - s), 8'h00);
    CMD_TARGET_SR1 = 1'b0;
    CMD_TARGET_CR1 = 1'b1;
    cmd(OP_WRITE_ANY_REGISTER_CMD, 8'h08);
    chk("starts", 8'(n_st - s), 8'h00);
    CMD_TARGET_SR1 = 1'b1;
    CMD_TARGET_CR1 = 1'b0;
    WP_N = 1'b1;
    cmd(OP_WRR, 8'h00);
    chk("starts", 8'(n_st - s), 8'h01);
    done(1'b0);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge CLOCK);
    NRST = 1'b1;
    repeat (2) @(negedge CLOCK);
    t_reset();
    t_ops();
    t_err();
    t_bp();
    t_more();
    t_lock();
    wrap_up();
  end
endmodule
